// file: design/io_port_defs.svh
// Offsets, field positions, reset values and timing counts of the I/O port block
// Operation
// - Each pin picks one of four types
// - Two configuration registers per port select type
// - Shared reset pin is input only
// - Quasi mode latched one drives weakly high
// - Latched zero drives low strongly when driving
// - Quasi mode uses three distinct pull-ups
// - Open drain: no pull-ups, low on zero
// - Input only: all drivers off
// - Push-pull drives strongly high on one
// - Every input passes hysteresis and glitch filter
// - Port 0 digital inputs disable per bit
// - Every reset clears Port 0 input disables
// - Power-up leaves all pins input only
// - Usable pin count follows clock, reset choice
// - Shared pin resets when enable bit set
// - Power-up always uses shared pin as reset
`ifndef IO_PORT_DEFS_SVH
`define IO_PORT_DEFS_SVH

// Register byte offsets
`define OFS_P0_DATA     12'h000
`define OFS_P0_CFG1     12'h004
`define OFS_P0_CFG2     12'h008
`define OFS_P1_DATA     12'h00c
`define OFS_P1_CFG1     12'h010
`define OFS_P1_CFG2     12'h014
`define OFS_P3_DATA     12'h018
`define OFS_P3_CFG1     12'h01c
`define OFS_P3_CFG2     12'h020
`define OFS_P0_IN_DIS   12'h024
`define OFS_USER_CFG1   12'h028
`define OFS_STATUS      12'h02c

// User configuration byte fields
`define UCFG_RPE_BIT    0
`define UCFG_CLK_LSB    1
`define UCFG_CLK_MSB    2

// Reset values: input-only everywhere (cfg1 = 1, cfg2 = 0)
`define RST_LATCH       8'hff
`define RST_CFG1        8'hff
`define RST_CFG2        8'h00
`define RST_IN_DIS      8'h00

// Pin map: port index (0 = P0, 1 = P1, 2 = P3) and bit
`define NUM_PINS        6
`define SHARED_PIN      3
`define PIN_PORTS       '{0, 0, 1, 1, 2, 2}
`define PIN_BITS        '{4, 5, 2, 5, 0, 1}

// Timing
`define CLK_FREQ_KHZ    40000
`define GLITCH_TIME_NS  50
`define POWERUP_TIME_US 10
`define QUASI_KICK_CYC  2

`endif

// file: design/io_port_pkg.sv
// Types shared by the I/O port block
`default_nettype none
package io_port_pkg;
   // Output type, two configuration bits {cfg1, cfg2}
   typedef enum logic [1:0] {
      MODE_QUASI = 2'b00,
      MODE_PUSH  = 2'b01,
      MODE_INPUT = 2'b10,
      MODE_OPEN  = 2'b11
   } pin_mode_e;
   typedef logic [7:0] byte_t;
endpackage
`default_nettype wire

// file: design/io_pin_cell.sv
// One pad cell: input synchroniser and glitch filter, output type decode
`default_nettype none
`include "io_port_defs.svh"
module io_pin_cell
   import io_port_pkg::*;
(
   // Clock and resets
   input  wire logic      clk_sys,
   input  wire logic      rstn,
   input  wire logic      soft_rst,
   // Control
   input  wire pin_mode_e mode,
   input  wire logic      latch,
   input  wire logic      in_disable,
   // Pad
   input  wire logic      pad_i,
   output logic           pad_o,
   output logic           pad_oe,
   output logic           pu_weak,
   output logic           pu_trickle,
   // Filtered level
   output logic           level
);
   localparam int GLITCH_CYC = (`GLITCH_TIME_NS * `CLK_FREQ_KHZ + 999999) / 1000000;

   logic       sync1_q, sync2_q;   // Synchroniser pair
   logic [3:0] stab_q;             // Stable count of candidate level
   logic       kick_on;            // Strong kick active
   logic [1:0] kick_q;             // Quasi kick countdown
   logic       latch_q;            // Previous latch, edge detect

   // Two flops before anything looks at the pad
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         sync1_q <= 1'b1;
         sync2_q <= 1'b1;
      end else begin
         sync1_q <= pad_i;
         sync2_q <= sync1_q;
      end
   end

   // Glitch filter: accept a new level only after it holds; analog pins read zero
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         level  <= 1'b1;
         stab_q <= 4'h0;
      end else if (in_disable) begin
         level  <= 1'b0;
         stab_q <= 4'h0;
      end else if (sync2_q == level) begin
         stab_q <= 4'h0;
      end else if (stab_q >= 4'(GLITCH_CYC - 1)) begin
         level  <= sync2_q;
         stab_q <= 4'h0;
      end else begin
         stab_q <= stab_q + 4'h1;
      end
   end

   // A new level must have stood two samples at the synchroniser output
   property p_glitch_reject;
      @(posedge clk_sys) disable iff (!rstn)
      $changed(level) && !$past(in_disable)
         |-> $past(sync2_q) == level && $past(sync2_q, 2) == level;
   endproperty
   a_glitch_reject: assert property (p_glitch_reject)
      else $error("pin level changed without a stable input");

   // Short strong pull-up after a quasi latch goes from zero to one
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         latch_q <= 1'b1;
         kick_q  <= 2'h0;
      end else begin
         latch_q <= latch;
         if (soft_rst || mode != MODE_QUASI || !latch) kick_q <= 2'h0;
         else if (!latch_q) kick_q <= 2'(`QUASI_KICK_CYC);
         else if (kick_q != 2'h0) kick_q <= kick_q - 2'h1;
      end
   end

   assign kick_on = (kick_q != 2'h0) || (!latch_q && latch);

   // Driver decode, registered so the pads see clean levels
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         pad_o      <= 1'b0;
         pad_oe     <= 1'b0;
         pu_weak    <= 1'b0;
         pu_trickle <= 1'b0;
      end else begin
         pad_o      <= 1'b0;
         pad_oe     <= 1'b0;
         pu_weak    <= 1'b0;
         pu_trickle <= 1'b0;
         unique case (mode)
            MODE_QUASI: begin
               if (!latch) begin
                  pad_oe <= 1'b1;
               end else begin
                  pu_trickle <= 1'b1;
                  pu_weak    <= level;
                  pad_o      <= kick_on;
                  pad_oe     <= kick_on;
               end
            end
            MODE_PUSH: begin
               pad_o  <= latch;
               pad_oe <= 1'b1;
            end
            MODE_OPEN: begin
               pad_oe <= !latch;
            end
            MODE_INPUT: begin
               pad_oe <= 1'b0;
            end
         endcase
      end
   end
endmodule // io_pin_cell
`default_nettype wire

// file: design/io_reset_pin.sv
// Shared reset pin: power-up window and reset-enable selection
`default_nettype none
`include "io_port_defs.svh"
module io_reset_pin (
   // Clock and reset
   input  wire logic clk_sys,
   input  wire logic rstn,
   // Filtered pin level and enable bit
   input  wire logic level,
   input  wire logic reset_pin_function_enable,
   // Results
   output logic      ext_reset_req,
   output logic      powerup
);
   localparam int PU_CYC = `POWERUP_TIME_US * `CLK_FREQ_KHZ / 1000;

   logic [11:0] pu_cnt_q; // Power-up window countdown

   // Window after power-on in which the pin always acts as reset
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         pu_cnt_q <= 12'(PU_CYC);
         powerup  <= 1'b1;
      end else begin
         if (pu_cnt_q != 12'h0) pu_cnt_q <= pu_cnt_q - 12'h1;
         powerup <= (pu_cnt_q > 12'h1);
      end
   end

   // Low pin requests reset; soft resets never reach rpe, so it is kept
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) ext_reset_req <= 1'b0;
      else ext_reset_req <= !level && (powerup || reset_pin_function_enable);
   end
endmodule // io_reset_pin
`default_nettype wire

// file: design/io_port_top.sv
// Configurable I/O port block with AXI4-Lite register access
`default_nettype none
`include "io_port_defs.svh"
module io_port_top
   import io_port_pkg::*;
(
   // Clock and resets
   input  wire logic        clk_sys,
   input  wire logic        rstn,
   input  wire logic        soft_rst,
   // AXI4-Lite write address
   input  wire logic [11:0] s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   // AXI4-Lite write data
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   // AXI4-Lite read address
   input  wire logic [11:0] s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   // AXI4-Lite read data
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   // Pads: strong drive and pull-ups
   input  wire logic [5:0]  pad_i,
   output logic [5:0]       pad_o,
   output logic [5:0]       pad_oe,
   output logic [5:0]       pad_pu_weak,
   output logic [5:0]       pad_pu_trickle,
   // Reset request from shared pin, active high
   output logic             ext_reset_req
);
   localparam int PIN_PORT [`NUM_PINS] = `PIN_PORTS;
   localparam int PIN_BIT  [`NUM_PINS] = `PIN_BITS;
   localparam logic [1:0] RESP_OKAY   = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;

   // Register state
   byte_t       latch_q [3];   // Output latches per port
   byte_t       cfg1_q  [3];   // First configuration register per port
   byte_t       cfg2_q  [3];   // Second configuration register per port
   byte_t       in_dis_q;      // Port 0 digital input disable
   logic        rpe_q;         // Reset pin function enable
   logic [1:0]  clksrc_q;      // 0 internal, 1 external clock, 2/3 crystal
   // Bus state
   logic [11:0] awaddr_q;      // Held write address
   logic        aw_have_q;     // Write address held
   logic [31:0] wdata_q;       // Held write data
   logic        wstrb0_q;      // Low lane enabled
   logic        w_have_q;      // Write data held
   logic        do_write;      // Both halves present this cycle
   // Pin side
   logic [5:0]  level;         // Filtered pin levels
   logic [5:0]  usable;        // Pins left over as I/O
   pin_mode_e   mode [`NUM_PINS]; // Effective type per pin
   logic [5:0]  pin_latch;     // Latch bit per pin
   logic [5:0]  pin_dis;       // Input disable per pin
   logic        powerup;       // Power-up window active
   logic [2:0]  pin_count;     // Number of usable I/O pins

   assign do_write = aw_have_q && w_have_q && !s_axi_bvalid;

   // Clock pins and the reset pin drop out of the I/O set
   always_comb begin
      usable = 6'h3f;
      if (clksrc_q == 2'h1) usable[5] = 1'b0;
      if (clksrc_q[1])      usable[5:4] = 2'b00;
      if (rpe_q)            usable[`SHARED_PIN] = 1'b0;
      pin_count = 3'(usable[0]) + 3'(usable[1]) + 3'(usable[2])
                + 3'(usable[3]) + 3'(usable[4]) + 3'(usable[5]);
   end

   // Per-pin type selection and pad cells
   for (genvar i = 0; i < `NUM_PINS; i++) begin : g_pin
      // Shared and non-usable pins are locked to input only
      assign mode[i] = (i == `SHARED_PIN || !usable[i]) ? MODE_INPUT
                     : pin_mode_e'({cfg1_q[PIN_PORT[i]][PIN_BIT[i]],
                                    cfg2_q[PIN_PORT[i]][PIN_BIT[i]]});
      assign pin_latch[i] = latch_q[PIN_PORT[i]][PIN_BIT[i]];
      assign pin_dis[i]   = (PIN_PORT[i] == 0) ? in_dis_q[PIN_BIT[i]] : 1'b0;

      io_pin_cell u_cell (
         .clk_sys    (clk_sys),
         .rstn       (rstn),
         .soft_rst   (soft_rst),
         .mode       (mode[i]),
         .latch      (pin_latch[i]),
         .in_disable (pin_dis[i]),
         .pad_i      (pad_i[i]),
         .pad_o      (pad_o[i]),
         .pad_oe     (pad_oe[i]),
         .pu_weak    (pad_pu_weak[i]),
         .pu_trickle (pad_pu_trickle[i]),
         .level      (level[i])
      );
   end

   // Shared reset pin logic
   io_reset_pin u_rst_pin (
      .clk_sys       (clk_sys),
      .rstn          (rstn),
      .level         (level[`SHARED_PIN]),
      .reset_pin_function_enable           (rpe_q),
      .ext_reset_req (ext_reset_req),
      .powerup       (powerup)
   );

   // Write address and data capture, either order
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         aw_have_q     <= 1'b0;
         w_have_q      <= 1'b0;
         awaddr_q      <= 12'h000;
         wdata_q       <= 32'h0000_0000;
         wstrb0_q      <= 1'b0;
         s_axi_awready <= 1'b1;
         s_axi_wready  <= 1'b1;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            awaddr_q      <= s_axi_awaddr;
            aw_have_q     <= 1'b1;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            wdata_q      <= s_axi_wdata;
            wstrb0_q     <= s_axi_wstrb[0];
            w_have_q     <= 1'b1;
            s_axi_wready <= 1'b0;
         end
         if (do_write) begin
            aw_have_q <= 1'b0;
            w_have_q  <= 1'b0;
         end
         // Accept the next write only once the response is taken
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
         end
      end
   end

   // Write response; unmapped offsets answer with an error
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= RESP_OKAY;
      end else if (do_write) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= (awaddr_q > `OFS_STATUS || awaddr_q[1:0] != 2'b00)
                         ? RESP_SLVERR : RESP_OKAY;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // Port latches and configuration; any reset returns pins to input only
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         for (int p = 0; p < 3; p++) begin
            latch_q[p] <= `RST_LATCH;
            cfg1_q[p]  <= `RST_CFG1;
            cfg2_q[p]  <= `RST_CFG2;
         end
         in_dis_q <= `RST_IN_DIS;
      end else if (soft_rst) begin
         for (int p = 0; p < 3; p++) begin
            latch_q[p] <= `RST_LATCH;
            cfg1_q[p]  <= `RST_CFG1;
            cfg2_q[p]  <= `RST_CFG2;
         end
         in_dis_q <= `RST_IN_DIS;
      end else if (do_write && wstrb0_q) begin
         unique case (awaddr_q)
            `OFS_P0_DATA:   latch_q[0] <= wdata_q[7:0];
            `OFS_P0_CFG1:   cfg1_q[0]  <= wdata_q[7:0];
            `OFS_P0_CFG2:   cfg2_q[0]  <= wdata_q[7:0];
            `OFS_P1_DATA:   latch_q[1] <= wdata_q[7:0];
            `OFS_P1_CFG1:   cfg1_q[1]  <= wdata_q[7:0];
            `OFS_P1_CFG2:   cfg2_q[1]  <= wdata_q[7:0];
            `OFS_P3_DATA:   latch_q[2] <= wdata_q[7:0];
            `OFS_P3_CFG1:   cfg1_q[2]  <= wdata_q[7:0];
            `OFS_P3_CFG2:   cfg2_q[2]  <= wdata_q[7:0];
            `OFS_P0_IN_DIS: in_dis_q   <= wdata_q[7:0];
            default: ;
         endcase
      end
   end

   // User configuration survives soft resets, only power-on clears it
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         rpe_q    <= 1'b0;
         clksrc_q <= 2'h0;
      end else if (do_write && wstrb0_q && awaddr_q == `OFS_USER_CFG1) begin
         rpe_q    <= wdata_q[`UCFG_RPE_BIT];
         clksrc_q <= wdata_q[`UCFG_CLK_MSB:`UCFG_CLK_LSB];
      end
   end

   // Read channel: data reads return filtered pin levels
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b1;
         s_axi_rresp   <= RESP_OKAY;
         s_axi_rdata   <= 32'h0000_0000;
         unique case (s_axi_araddr)
            `OFS_P0_DATA:   s_axi_rdata[7:0] <= {2'b00, level[1:0], 4'h0};
            `OFS_P0_CFG1:   s_axi_rdata[7:0] <= cfg1_q[0];
            `OFS_P0_CFG2:   s_axi_rdata[7:0] <= cfg2_q[0];
            `OFS_P1_DATA:   s_axi_rdata[7:0] <= {2'b00, level[3], 2'b00, level[2], 2'b00};
            `OFS_P1_CFG1:   s_axi_rdata[7:0] <= cfg1_q[1];
            `OFS_P1_CFG2:   s_axi_rdata[7:0] <= cfg2_q[1];
            `OFS_P3_DATA:   s_axi_rdata[7:0] <= {6'h00, level[5:4]};
            `OFS_P3_CFG1:   s_axi_rdata[7:0] <= cfg1_q[2];
            `OFS_P3_CFG2:   s_axi_rdata[7:0] <= cfg2_q[2];
            `OFS_P0_IN_DIS: s_axi_rdata[7:0] <= in_dis_q;
            `OFS_USER_CFG1: s_axi_rdata[7:0] <= {5'h00, clksrc_q, rpe_q};
            `OFS_STATUS:    s_axi_rdata[7:0] <= {3'h0, powerup, ext_reset_req,
                                                 pin_count};
            default:        s_axi_rresp <= RESP_SLVERR;
         endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid  <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end

   // Checks on pad and reset behaviour; pad 0 (port 0 bit 4) stands for the configurable pins
   sequence s_quasi_one;
      (mode[0] == MODE_QUASI && pin_latch[0] && !soft_rst)[*4];
   endsequence

   property p_shared_input_only;
      @(posedge clk_sys) disable iff (!rstn)
      !pad_oe[`SHARED_PIN] && !pad_pu_weak[`SHARED_PIN] && !pad_pu_trickle[`SHARED_PIN];
   endproperty
   a_shared_input_only: assert property (p_shared_input_only)
      else $error("shared pin drives");

   property p_input_hiz;
      @(posedge clk_sys) disable iff (!rstn)
      mode[0] == MODE_INPUT |=> !pad_oe[0] && !pad_pu_weak[0] && !pad_pu_trickle[0];
   endproperty
   a_input_hiz: assert property (p_input_hiz)
      else $error("input-only pin not high impedance");

   property p_strong_low;
      @(posedge clk_sys) disable iff (!rstn)
      mode[0] != MODE_INPUT && !pin_latch[0] |=> pad_oe[0] && !pad_o[0];
   endproperty
   a_strong_low: assert property (p_strong_low)
      else $error("latched zero not driven low");

   property p_open_drain;
      @(posedge clk_sys) disable iff (!rstn)
      mode[0] == MODE_OPEN |=> pad_oe[0] == !$past(pin_latch[0]) && !pad_pu_weak[0]
                               && !pad_pu_trickle[0] && !pad_o[0];
   endproperty
   a_open_drain: assert property (p_open_drain)
      else $error("open drain drive wrong");

   property p_push_high;
      @(posedge clk_sys) disable iff (!rstn)
      mode[0] == MODE_PUSH && pin_latch[0] |=> pad_oe[0] && pad_o[0];
   endproperty
   a_push_high: assert property (p_push_high)
      else $error("push-pull one not driven high");

   property p_quasi_weak;
      @(posedge clk_sys) disable iff (!rstn)
      s_quasi_one |=> !pad_oe[0] && pad_pu_trickle[0];
   endproperty
   a_quasi_weak: assert property (p_quasi_weak)
      else $error("quasi one driven strongly");

   property p_soft_reset_clears;
      @(posedge clk_sys) disable iff (!rstn)
      soft_rst |=> in_dis_q == 8'h00 && cfg1_q[0] == 8'hff && cfg2_q[0] == 8'h00;
   endproperty
   a_soft_reset_clears: assert property (p_soft_reset_clears)
      else $error("reset left disables or types set");

   property p_rpe_kept;
      @(posedge clk_sys) disable iff (!rstn)
      soft_rst |=> rpe_q == $past(rpe_q);
   endproperty
   a_rpe_kept: assert property (p_rpe_kept)
      else $error("soft reset changed reset pin enable");

   property p_reset_pin;
      @(posedge clk_sys) disable iff (!rstn)
      !powerup && rpe_q && !level[`SHARED_PIN] ##1 !level[`SHARED_PIN] |-> ext_reset_req;
   endproperty
   a_reset_pin: assert property (p_reset_pin)
      else $error("low shared pin gave no reset");

   // Rising quasi latch: low for one sample, then high
   sequence s_quasi_rise;
      mode[0] == MODE_QUASI && !pin_latch[0] ##1 mode[0] == MODE_QUASI && pin_latch[0];
   endsequence

   property p_quasi_kick;
      @(posedge clk_sys) disable iff (!rstn)
      s_quasi_rise |=> pad_oe[0] && pad_o[0];
   endproperty
   a_quasi_kick: assert property (p_quasi_kick)
      else $error("quasi rise gave no strong kick");

   property p_quasi_weak_level;
      @(posedge clk_sys) disable iff (!rstn)
      s_quasi_one |=> pad_pu_weak[0] == $past(level[0]);
   endproperty
   a_quasi_weak_level: assert property (p_quasi_weak_level)
      else $error("weak pull-up does not follow the pin");

   property p_powerup_reset;
      @(posedge clk_sys) disable iff (!rstn)
      powerup && !level[`SHARED_PIN] |=> ext_reset_req;
   endproperty
   a_powerup_reset: assert property (p_powerup_reset)
      else $error("low shared pin ignored in power-up window");

   property p_pin_plain_input;
      @(posedge clk_sys) disable iff (!rstn)
      !powerup && !rpe_q |=> !ext_reset_req;
   endproperty
   a_pin_plain_input: assert property (p_pin_plain_input)
      else $error("shared pin reset while its function is off");

   property p_clock_pin_input;
      @(posedge clk_sys) disable iff (!rstn)
      !usable[5] |=> !pad_oe[5] && !pad_pu_weak[5] && !pad_pu_trickle[5];
   endproperty
   a_clock_pin_input: assert property (p_clock_pin_input)
      else $error("clock pin still drives");
endmodule // io_port_top
`default_nettype wire

// file: design/io_port_top_unused_guard.sv
// Empty unit: holds no module
`default_nettype none
`default_nettype wire

// file: sim/board_model.sv
// Board circuitry model that resolves the six package pins
`default_nettype none
module board_model (
   // Strong drive from the port block
   input  wire logic [5:0] pad_o,
   input  wire logic [5:0] pad_oe,
   // External driver requested by the bench
   input  wire logic [5:0] ext_en,
   input  wire logic [5:0] ext_val,
   // Resolved pin levels
   output logic      [5:0] pad_i
);
   timeunit 1ns;
   timeprecision 100ps;
   // Strong drive wins; an external driver overpowers the weak pull-ups
   // a released pin floats high through the board resistor
   always_comb begin
      for (int i = 0; i < 6; i++) begin
         pad_i[i] = pad_oe[i] ? pad_o[i] : (ext_en[i] ? ext_val[i] : 1'b1);
      end
   end
endmodule // board_model
`default_nettype wire

// file: sim/tb.sv
// Register-level testbench for the I/O port block
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 100ps;
   logic        clk_sys, rstn, soft_rst;
   logic [11:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, rdat;
   logic [3:0]  s_axi_wstrb;
   logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
   logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic        s_axi_rvalid, s_axi_rready, ext_reset_req, ha, hw;
   logic [5:0]  pad_i, pad_o, pad_oe, pad_pu_weak, pad_pu_trickle;
   logic [5:0]  ext_en, ext_val;  // Board drive requests
   logic [6:0]  mt [7];           // {cfg1, cfg2, latch, oe, o, trickle, weak}
   int          n_fail, check_count, g;
   io_port_top u_dut (.clk_sys, .rstn, .soft_rst, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
      .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
      .pad_i, .pad_o, .pad_oe, .pad_pu_weak, .pad_pu_trickle, .ext_reset_req);
   board_model u_board (.pad_o, .pad_oe, .ext_en, .ext_val, .pad_i);
   // Free-running system clock
   initial begin
      clk_sys = 0;
      forever #12.5 clk_sys = ~clk_sys;
   end
   // Verdict and end of run
   task automatic results;
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   // Bounds every wait loop so a hang ends the run
   task automatic guard;
      g++;
      if (g > 200) begin
         n_fail++;
         results;
      end
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         n_fail++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // Write: both channels offered together, each released once taken
   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      s_axi_awaddr <= a; s_axi_wdata <= {24'h0, d};
      s_axi_awvalid <= 1; s_axi_wvalid <= 1; s_axi_bready <= 1;
      g = 0; ha = 0; hw = 0;
      while (!ha || !hw) begin
         @(negedge clk_sys);
         if (s_axi_awready) ha = 1;
         if (s_axi_wready) hw = 1;
         @(posedge clk_sys);
         if (ha) s_axi_awvalid <= 0;
         if (hw) s_axi_wvalid <= 0;
         guard;
      end
      hw = 0;
      while (!hw) begin
         @(negedge clk_sys);
         hw = s_axi_bvalid;
         resp = s_axi_bresp;
         @(posedge clk_sys);
         guard;
      end
      s_axi_bready <= 0;
   endtask
   // Read: address held until taken, data captured on the falling edge before the handshake edge
   task automatic rd(input logic [11:0] a);
      @(posedge clk_sys);
      s_axi_araddr <= a; s_axi_arvalid <= 1; s_axi_rready <= 1;
      g = 0; ha = 0; hw = 0;
      while (!hw) begin
         @(negedge clk_sys);
         ha = s_axi_arready & s_axi_arvalid;
         hw = s_axi_rvalid;
         rdat = s_axi_rdata; resp = s_axi_rresp;
         @(posedge clk_sys);
         if (ha) s_axi_arvalid <= 0;
         guard;
      end
      s_axi_rready <= 0;
   endtask
   task automatic rdc(input logic [11:0] a, input logic [31:0] e);
      rd(a);
      chk(rdat, e);
   endtask
   task automatic settle;
      repeat (12) @(posedge clk_sys);
      @(negedge clk_sys);
   endtask
   initial begin
      mt = '{7'b000_1000, 7'b001_0011, 7'b011_1100, 7'b010_1000,
             7'b111_0000, 7'b110_1000, 7'b100_0000};
      rstn = 0; soft_rst = 0; s_axi_wstrb = 4'hf;
      s_axi_awaddr = 0; s_axi_awvalid = 0; s_axi_wdata = 0; s_axi_wvalid = 0;
      s_axi_bready = 0; s_axi_araddr = 0; s_axi_arvalid = 0; s_axi_rready = 0;
      ext_en = 6'h08; ext_val = 6'h00;  // Shared pin held low at power-up
      n_fail = 0; check_count = 0;
      repeat (8) @(posedge clk_sys);
      rstn <= 1;
      settle;
      chk(ext_reset_req, 1);
      chk(pad_oe, 0);
      ext_val[3] <= 1;
      rdc(12'h004, 32'hff);
      rdc(12'h008, 32'h00);
      rdc(12'h024, 32'h00);
      rd(12'h100);
      chk(resp, 2'b10);
      wr(12'h100, 8'h55);
      chk(resp, 2'b10);
      $display("test reset_values done");
      // Every type code on pad 0, quasi low then trickle and weak pull-up
      for (int i = 0; i < 7; i++) begin
         wr(12'h004, mt[i][6] ? 8'h10 : 8'h00);
         wr(12'h008, mt[i][5] ? 8'h10 : 8'h00);
         wr(12'h000, mt[i][4] ? 8'h10 : 8'h00);
         settle;
         chk({pad_oe[0], pad_o[0] & pad_oe[0], pad_pu_trickle[0], pad_pu_weak[0]},
             mt[i][3:0]);
      end
      $display("test pin_types done");
      // Pad 0 is input-only now; pad 1 drives low
      ext_en[0] <= 1;
      settle;
      rdc(12'h000, 32'h00);
      ext_val[0] <= 1;
      settle;
      rdc(12'h000, 32'h10);
      ext_val[0] <= 0;
      @(posedge clk_sys);
      ext_val[0] <= 1;
      settle;
      rdc(12'h000, 32'h10);
      wr(12'h024, 8'h10);
      rdc(12'h000, 32'h00);
      $display("test input_path done");
      wr(12'h010, 8'h00);
      wr(12'h014, 8'hff);
      wr(12'h00c, 8'hff);
      settle;
      chk(pad_oe[3], 0);
      chk(pad_oe[2], 1);
      $display("test shared_pin done");
      wr(12'h01c, 8'h00);
      wr(12'h020, 8'h03);
      for (int c = 0; c < 4; c++) begin
         for (int r = 0; r < 2; r++) begin
            wr(12'h028, 8'(c * 2 + r));
            rd(12'h02c);
            chk(rdat & 32'h7, 32'(6 - (c > 1 ? 2 : c) - r));
         end
      end
      wr(12'h028, 8'h00);
      $display("test pin_count done");
      soft_rst <= 1;
      @(posedge clk_sys);
      soft_rst <= 0;
      wr(12'h028, 8'h05);
      soft_rst <= 1;
      @(posedge clk_sys);
      soft_rst <= 0;
      rdc(12'h024, 32'h00);
      rdc(12'h014, 32'h00);
      rd(12'h02c);
      chk(rdat & 32'h7, 32'h3);
      wr(12'h028, 8'h00);
      $display("test soft_reset done");
      repeat (400) @(posedge clk_sys);
      wr(12'h028, 8'h01);
      ext_val[3] <= 0;
      settle;
      chk(ext_reset_req, 1);
      wr(12'h028, 8'h00);
      settle;
      chk(ext_reset_req, 0);
      ext_val[3] <= 1;
      $display("test reset_pin done");
      results;
   end
endmodule // tb
`default_nettype wire
